// ### core/fbp_flash_protect.sv
// Flash array of 96 erase units with per-2 KB read/write protection.
// Assumes all request inputs come from logic on core_clk; storage is
// modelled as flip-flops indexed by word address.
`timescale 1ns/100ps

// Overview of operation
// - 96 KB array, 1 KB units erased alone
// - Erased unit reads all ones
// - Two 1 KB units share one protection
// - Levels: read-only or execute-only, distinct
// - Read-only refuses erase and program
// - Execute-only allows only instruction fetch reads
module fbp_flash_protect
(
   input  wire logic        core_clk,     // System clock
   input  wire logic        rst_b,        // Async reset, active low
   input  wire logic        prot_set,     // Load protection pulse
   input  wire logic [5:0]  prot_idx,     // Protection unit index
   input  wire logic [1:0]  prot_level,   // Level to load
   input  wire logic        erase_req,    // Erase unit pulse
   input  wire logic [6:0]  erase_unit,   // Unit to erase
   input  wire logic        prog_req,     // Program word pulse
   input  wire logic [14:0] prog_addr,    // Word to program
   input  wire logic [31:0] prog_data,    // Program data
   input  wire logic        rd_req,       // Read pulse
   input  wire logic        rd_fetch,     // Read is instruction fetch
   input  wire logic        rd_dbg,       // Read is from debugger
   input  wire logic [14:0] rd_addr,      // Word to read
   output logic             op_done,      // Erase/program accepted
   output logic             op_refused,   // Erase/program refused
   output logic             rd_valid,     // Read answer pulse
   output logic [31:0]      rd_data,      // Read answer data
   output logic             rd_denied,    // Read was denied
   output logic [95:0]      unit_erased   // Unit erased after reset, not programmed since
);

   // ------------------------------------------------------------
   // Storage and decode
   // ------------------------------------------------------------
   // Array words hold no reset; contents are undefined until erased
   localparam int WORDS = fbp_pkg::NUM_UNITS * fbp_pkg::UNIT_WORDS;
   logic [31:0] mem [WORDS];                    // Array words
   logic [1:0]  level [fbp_pkg::NUM_PROT];      // Level per 2 KB unit
   logic [fbp_pkg::NUM_PROT-1:0] mod_ok;        // Modify allowed
   logic [6:0]  prog_unit;                      // Unit of program addr
   logic [6:0]  rd_unit;                        // Unit of read addr
   logic        erase_ok;                       // Erase passes gate
   logic        prog_ok;                        // Program passes gate
   logic        rd_ok;                          // Read passes gate
   logic        erase_in;                       // Erase index in range
   logic        prog_in;                        // Program addr in range
   logic        rd_in;                          // Read addr in range

   // Upper address bits pick the 1 KB unit; units past the top refuse
   assign prog_unit = prog_addr[14:8];
   assign rd_unit   = rd_addr[14:8];
   assign erase_in  = erase_unit < 7'(fbp_pkg::NUM_UNITS);
   assign prog_in   = prog_unit < 7'(fbp_pkg::NUM_UNITS);
   assign rd_in     = rd_unit < 7'(fbp_pkg::NUM_UNITS);

   // ------------------------------------------------------------
   // Protection units, one per pair of erase units
   // ------------------------------------------------------------
   for (genvar p = 0; p < fbp_pkg::NUM_PROT; p++)
   begin : g_prot
      fbp_unit_ctl u_ctl
      (
         .core_clk  (core_clk),
         .rst_b     (rst_b),
         .set_en    (prot_set && prot_idx == 6'(p)),
         .set_level (prot_level),
         .level     (level[p]),
         .modify_ok (mod_ok[p])
      );
   end

   // Unnamed level 3 reads as open but still blocks modify
   // Pair mapping: unit index bit 0 dropped
   assign erase_ok = erase_in && mod_ok[erase_unit[6:1]];
   assign prog_ok  = prog_in && mod_ok[prog_unit[6:1]];
   // Execute-only reads only by fetch; debug counts as data
   assign rd_ok    = rd_in &&
                     (level[rd_unit[6:1]] != fbp_pkg::FBP_XONLY ||
                      (rd_fetch && !rd_dbg));

   // ------------------------------------------------------------
   // Array update: erase whole unit or program one word
   // ------------------------------------------------------------
   // Erase beats program; no reset here, so the array survives rst_b
   // Program ANDs data in: a cell only goes from one to zero
   always_ff @(posedge core_clk)
      for (int w = 0; w < WORDS; w++)
      begin
         if (erase_req && erase_ok &&
             erase_unit == 7'(w / fbp_pkg::UNIT_WORDS))
            mem[w] <= fbp_pkg::ERASED_WORD;
         else if (prog_req && prog_ok && prog_addr == 15'(w))
            mem[w] <= mem[w] & prog_data;               // Flash clears bits
      end

   // Per-unit erased flags
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
         unit_erased <= '0;
      else
         for (int u = 0; u < fbp_pkg::NUM_UNITS; u++)
         begin
            if (erase_req && erase_ok && erase_unit == 7'(u))
               unit_erased[u] <= 1'b1;
            else if (prog_req && prog_ok && prog_unit == 7'(u))
               unit_erased[u] <= 1'b0;
         end

   // ------------------------------------------------------------
   // Request status
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
      begin
         op_done    <= 1'b0;
         op_refused <= 1'b0;
      end
      else
      begin
         // A program in the same cycle as an erase gets no status pulse
         // Erase has priority over program in one cycle
         op_done    <= erase_req ? erase_ok : (prog_req && prog_ok);
         op_refused <= erase_req ? !erase_ok
                                 : (prog_req && !prog_ok);
      end

   // ------------------------------------------------------------
   // Read path: one cycle latency
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
      begin
         rd_valid  <= 1'b0;
         rd_data   <= fbp_pkg::DENY_WORD;
         rd_denied <= 1'b0;
      end
      else
      begin
         // Answer pulses follow each request by one cycle
         rd_valid  <= rd_req;
         rd_denied <= rd_req && !rd_ok;
         if (rd_req)
            rd_data <= rd_ok ? mem[rd_addr] : fbp_pkg::DENY_WORD;
      end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // ------------------------------------------------------------
   // Erase and modify checks
   // ------------------------------------------------------------
   // First and last word of an erased unit read all ones
   erase_all_ones_a: assert property (
      erase_req && erase_ok
      |=> mem[{$past(erase_unit), 8'h00}] == fbp_pkg::ERASED_WORD &&
          mem[{$past(erase_unit), 8'hFF}] == fbp_pkg::ERASED_WORD)
      else $error("erased unit did not read all ones");
   // Read-only unit refuses erase
   ro_refuse_a: assert property (
      erase_req && level[erase_unit[6:1]] == fbp_pkg::FBP_RDONLY
      |=> op_refused && !op_done)
      else $error("erase of read-only unit accepted");
   // Odd unit follows the level of its pair
   pair_share_a: assert property (
      erase_req && erase_in && erase_unit[0] == 1'b1 &&
      level[erase_unit[6:1]] != fbp_pkg::FBP_OPEN
      |=> op_refused)
      else $error("odd unit of protected pair erased");
   // Refused erase leaves the unit's first word as it was
   deny_untouched_a: assert property (
      erase_req && erase_in && !erase_ok
      |=> mem[{$past(erase_unit), 8'h00}] ==
          $past(mem[{erase_unit, 8'h00}]))
      else $error("refused erase changed array");
   // Refused program leaves its word as it was
   prog_keep_a: assert property (
      prog_req && !erase_req && prog_in && !prog_ok
      |=> mem[$past(prog_addr)] == $past(mem[prog_addr]))
      else $error("refused program changed array");
   // Accepted erase raises the unit's flag
   erase_flag_a: assert property (
      erase_req && erase_ok |=> unit_erased[$past(erase_unit)])
      else $error("erased flag not set");
   // Status is accept or refuse, never both
   op_excl_a: assert property (
      !(op_done && op_refused))
      else $error("accept and refuse raised together");

   // ------------------------------------------------------------
   // Read checks
   // ------------------------------------------------------------
   // Data read of execute-only unit gets the deny word
   xo_data_deny_a: assert property (
      rd_req && rd_in && (!rd_fetch || rd_dbg) &&
      level[rd_unit[6:1]] == fbp_pkg::FBP_XONLY
      |=> rd_denied && rd_data == fbp_pkg::DENY_WORD)
      else $error("data read of execute-only unit returned");
   // Clean fetch of an in-range unit is never denied
   xo_fetch_ok_a: assert property (
      rd_req && rd_fetch && !rd_dbg && rd_in
      |=> !rd_denied)
      else $error("instruction fetch was denied");
   // Read-only units stay readable as data
   ro_data_ok_a: assert property (
      rd_req && rd_in && level[rd_unit[6:1]] == fbp_pkg::FBP_RDONLY
      |=> !rd_denied)
      else $error("data read of read-only unit denied");
   // Each read answers exactly one cycle later
   read_lat_a: assert property (
      rd_req |=> rd_valid ##1 (rd_valid == $past(rd_req)))
      else $error("read answer timing wrong");

   // Main scenarios seen
   erase_cov_c: cover property (erase_req && erase_ok);
   ro_cov_c: cover property (erase_req && !erase_ok);
   xo_fetch_cov_c: cover property (rd_req && rd_fetch &&
      level[rd_unit[6:1]] == fbp_pkg::FBP_XONLY);
   spare_cov_c: cover property (erase_req && erase_in &&
      level[erase_unit[6:1]] != fbp_pkg::FBP_OPEN &&
      level[erase_unit[6:1]] != fbp_pkg::FBP_RDONLY &&
      level[erase_unit[6:1]] != fbp_pkg::FBP_XONLY);

endmodule

// ### core/fbp_pkg.sv
// Constants shared by the flash erase and protection block.
// Assumes a 32-bit wide flash array addressed by word index.
package fbp_pkg;

   // ------------------------------------------------------------
   // Array geometry
   // ------------------------------------------------------------
   localparam int ARRAY_KB      = 96;              // Total array size
   localparam int UNIT_KB       = 1;               // Erase unit size
   localparam int WORD_BYTES    = 4;               // Bytes per word
   localparam int UNIT_WORDS    = UNIT_KB * 1024 / WORD_BYTES;
   localparam int NUM_UNITS     = ARRAY_KB / UNIT_KB;
   localparam int NUM_PROT      = NUM_UNITS / 2;   // 2 KB protect units
   localparam int ADDR_W        = 15;              // Word address width
   localparam int OFS_W         = 8;               // Word within unit
   localparam int UNIT_W        = 7;               // Unit index width
   localparam int PROT_W        = 6;               // Protect index width
   localparam int DATA_W        = 32;              // Word width

   // ------------------------------------------------------------
   // Data values
   // ------------------------------------------------------------
   localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF; // Erased state
   localparam logic [31:0] DENY_WORD   = 32'h0000_0000; // Denied read

   // ------------------------------------------------------------
   // Protection levels, two bits per 2 KB unit
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FBP_OPEN   = 2'h0,
      FBP_RDONLY = 2'h1,
      FBP_XONLY  = 2'h2
   } fbp_prot_t;
   localparam logic [1:0] PROT_RESET = 2'h0;   // Level after reset

endpackage

// ### core/fbp_unit_ctl.sv
// One 2 KB protection unit: its protection level and its write gate.
// Assumes requests are already synchronous to core_clk.
`timescale 1ns/100ps
module fbp_unit_ctl
(
   input  wire logic       core_clk,   // System clock
   input  wire logic       rst_b,      // Async reset, active low
   input  wire logic       set_en,     // Load new level
   input  wire logic [1:0] set_level,  // Level to load
   output logic      [1:0] level,      // Current level
   output logic            modify_ok   // Erase and program allowed
);

   // ------------------------------------------------------------
   // Level register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
         level <= fbp_pkg::PROT_RESET;
      else if (set_en)
         level <= set_level;

   // Any protected level blocks modification
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
         modify_ok <= 1'b1;
      else if (set_en)
         modify_ok <= (set_level == fbp_pkg::FBP_OPEN);

endmodule

// ### tb/fbp_host_model.sv
// Model of the CPU fetch, CPU data and debugger read side.
// Assumes the flash block answers one cycle after each read pulse.
`timescale 1ns/100ps
module fbp_host_model
(
   input  wire logic        core_clk,  // System clock
   input  wire logic        rd_valid,  // Read answer pulse
   input  wire logic [31:0] rd_data,   // Read answer data
   input  wire logic        rd_denied, // Read was denied
   output logic             rd_req,    // Read pulse
   output logic             rd_fetch,  // Instruction fetch
   output logic             rd_dbg,    // Debugger access
   output logic      [14:0] rd_addr    // Word address
);
   // Idle read side from time zero
   initial {rd_req, rd_fetch, rd_dbg, rd_addr} = '0;

   // One read: pulse for a cycle, take the answer a cycle later
   task automatic rd(input logic [14:0] a, input logic f, input logic g,
                     output logic v, output logic [31:0] d, output logic n);
      @(posedge core_clk);
      #1 rd_req = 1'b1;
      rd_fetch = f;
      rd_dbg = g;
      rd_addr = a;
      @(posedge core_clk);
      #1 rd_req = 1'b0;
      v = rd_valid;
      d = rd_data;
      n = rd_denied;
      rd_addr = ~a; // Released address does not stay stale
   endtask
endmodule

// ### tb/tb_fbp_flash_protect.sv
// Self-checking bench for the flash erase and protection block.
// Assumes the host model drives reads; this bench drives the rest.
`timescale 1ns/100ps
module tb_fbp_flash_protect;
   logic core_clk, rst_b, prot_set, erase_req, prog_req;
   logic rd_req, rd_fetch, rd_dbg, rd_valid, rd_denied;
   logic op_done, op_refused;
   logic [5:0] prot_idx;
   logic [1:0] prot_level;
   logic [6:0] erase_unit;
   logic [14:0] prog_addr, rd_addr;
   logic [31:0] prog_data, rd_data;
   logic [95:0] unit_erased;
   int err_total = 0;
   int tests_run = 0;
   localparam logic [31:0] PVAL = 32'h1234_0078; // 12345678 AND FFFF00FF

   fbp_flash_protect fbp_flash_protect_inst (.*);
   fbp_host_model fbp_host_model_inst (.core_clk(core_clk),
      .rd_valid(rd_valid), .rd_data(rd_data), .rd_denied(rd_denied),
      .rd_req(rd_req), .rd_fetch(rd_fetch), .rd_dbg(rd_dbg),
      .rd_addr(rd_addr));

   // ----------------------------------------
   // Clock, shared checks and bus tasks
   // ----------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic chk(input logic c, input string m);
      tests_run++;
      if (c !== 1'b1)
      begin
         err_total++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Erase (e=1) or program pulse, then accept or refuse status
   task automatic op(input logic e, input logic [6:0] u,
      input logic [14:0] a, input logic [31:0] d, input logic ok);
      @(posedge core_clk);
      #1 {erase_req, prog_req, erase_unit} = {e, !e, u};
      {prog_addr, prog_data} = {a, d};
      @(posedge core_clk);
      #1 {erase_req, prog_req} = 2'b00;
      chk(op_done === ok && op_refused === !ok, "op status");
   endtask
   task automatic prot(input logic [5:0] i, input logic [1:0] l);
      @(posedge core_clk);
      #1 {prot_set, prot_idx, prot_level} = {1'b1, i, l};
      @(posedge core_clk);
      #1 prot_set = 1'b0;
   endtask
   task automatic rdx(input logic [14:0] a, input logic f, input logic g,
      input logic [31:0] x, input logic dn);
      logic v, n;
      logic [31:0] d;
      fbp_host_model_inst.rd(a, f, g, v, d, n);
      chk(v === 1'b1 && d === x && n === dn, "read answer");
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_erase();
      op(1'b1, 7'h04, 15'h0, 32'h0, 1'b1);
      op(1'b1, 7'h5F, 15'h0, 32'h0, 1'b1);
      chk(unit_erased[4] === 1'b1 && unit_erased[5] === 1'b0, "unit");
      op(1'b1, 7'h05, 15'h0, 32'h0, 1'b1);
      op(1'b1, 7'h60, 15'h0, 32'h0, 1'b0);
      rdx(15'h0400, 1'b0, 1'b0, fbp_pkg::ERASED_WORD, 1'b0);
      rdx(15'h04FF, 1'b0, 1'b0, fbp_pkg::ERASED_WORD, 1'b0);
      $display("erase test done");
   endtask
   task automatic t_prog();
      op(1'b0, 7'h0, 15'h0410, 32'h1234_5678, 1'b1);
      op(1'b0, 7'h0, 15'h0410, 32'hFFFF_00FF, 1'b1);
      rdx(15'h0410, 1'b0, 1'b0, PVAL, 1'b0);
      chk(unit_erased[4] === 1'b0 && unit_erased[95] === 1'b1, "flag");
      $display("program test done");
   endtask
   task automatic t_rdonly();
      prot(6'h02, fbp_pkg::FBP_RDONLY);
      op(1'b1, 7'h05, 15'h0, 32'h0, 1'b0);
      op(1'b0, 7'h0, 15'h0411, 32'h0, 1'b0);
      op(1'b1, 7'h06, 15'h0, 32'h0, 1'b1);
      rdx(15'h0410, 1'b0, 1'b1, PVAL, 1'b0);
      $display("read-only test done");
   endtask
   task automatic t_xonly();
      prot(6'h02, fbp_pkg::FBP_XONLY);
      rdx(15'h0410, 1'b1, 1'b0, PVAL, 1'b0);
      rdx(15'h0410, 1'b0, 1'b0, fbp_pkg::DENY_WORD, 1'b1);
      rdx(15'h0410, 1'b0, 1'b1, fbp_pkg::DENY_WORD, 1'b1);
      rdx(15'h0410, 1'b1, 1'b1, fbp_pkg::DENY_WORD, 1'b1);
      op(1'b1, 7'h04, 15'h0, 32'h0, 1'b0);
      op(1'b0, 7'h0, 15'h0500, 32'h0, 1'b0);
      $display("execute-only test done");
   endtask
   task automatic t_reopen();
      prot(6'h02, 2'h3);
      op(1'b1, 7'h04, 15'h0, 32'h0, 1'b0);
      rdx(15'h0410, 1'b0, 1'b1, PVAL, 1'b0);
      prot(6'h02, fbp_pkg::FBP_OPEN);
      rdx(15'h6000, 1'b1, 1'b0, fbp_pkg::DENY_WORD, 1'b1);
      op(1'b1, 7'h05, 15'h0, 32'h0, 1'b1);
      rdx(15'h0410, 1'b0, 1'b0, PVAL, 1'b0);
      rdx(15'h0500, 1'b0, 1'b0, fbp_pkg::ERASED_WORD, 1'b0);
      $display("reopen test done");
   endtask
   task automatic t_reset();
      prot(6'h02, fbp_pkg::FBP_RDONLY);
      @(posedge core_clk);
      #1 rst_b = 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk(unit_erased === '0 && rd_valid === 1'b0, "reset");
      rst_b = 1'b1;
      op(1'b1, 7'h05, 15'h0, 32'h0, 1'b1);
      rdx(15'h0500, 1'b0, 1'b0, fbp_pkg::ERASED_WORD, 1'b0);
      $display("reset test done");
   endtask

   // Reset, then run all scenarios
   initial
   begin
      {rst_b, prot_set, erase_req, prog_req} = 4'h0;
      {prot_idx, prot_level, erase_unit, prog_addr, prog_data} = '0;
      repeat (20) @(posedge core_clk);
      #1 rst_b = 1'b1;
      t_erase();
      t_prog();
      t_rdonly();
      t_xonly();
      t_reopen();
      t_reset();
      give_verdict();
   end
   // Watchdog well past the expected ninety or so cycles
   initial
   begin
      #100000;
      err_total++;
      give_verdict();
   end
endmodule
